// File: pkg/tx_test_pattern_pkg.sv
package tx_test_pattern_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS   = 25000;
    localparam int SYMBOL_TIME_PS  = 15000;
    // Longest interval: round down, never below one cycle
    localparam int SYM_CYCLES_RAW  = SYMBOL_TIME_PS / CLK_PERIOD_PS;
    localparam int SYMBOL_CYCLES   = (SYM_CYCLES_RAW < 1) ? 1 : SYM_CYCLES_RAW;

    // ****************************************************************
    // Test mode selection codes on the mode pins
    // ****************************************************************
    localparam int          MODE_W       = 3;
    localparam logic [2:0]  TM_CODE_3    = 3'h3;
    localparam logic [2:0]  TM_CODE_4    = 3'h4;
    localparam logic [2:0]  TM_CODE_5    = 3'h5;
    localparam logic        TM3_SUPPORTED = 1'b1;

    // ****************************************************************
    // Ternary symbol codes (two bit, sign and magnitude style)
    // ****************************************************************
    localparam int          SYM_W    = 2;
    localparam logic [1:0]  SYM_ZERO = 2'h0;
    localparam logic [1:0]  SYM_POS  = 2'h1;
    localparam logic [1:0]  SYM_NEG  = 2'h3;

    // ****************************************************************
    // Pattern generator polynomials
    // ****************************************************************
    // Maximal length 2047: new bit = bit 11 steps back xor bit 9 steps back
    localparam int PN_LEN    = 11;
    localparam int PN_TAP_A  = 10;
    localparam int PN_TAP_B  = 8;
    // History taps of the pattern bit used for the high bit of the pair
    localparam int PN_HIST_A = 0;
    localparam int PN_HIST_B = 3;
    // Side-stream scrambler geometry, plain defaults
    localparam int SS_LEN    = 33;
    localparam int SS_TAP_A  = 32;
    localparam int SS_TAP_B  = 19;
    localparam int SS_HIST_A = 2;
    localparam int SS_HIST_B = 7;

    // ****************************************************************
    // Pattern state, Gray coded along normal, 3, 4, 5
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_NORMAL = 2'h0,
        ST_TM3    = 2'h1,
        ST_TM4    = 2'h3,
        ST_TM5    = 2'h2
    } pattern_state_t;

endpackage : tx_test_pattern_pkg

// File: rtl/pattern_lfsr.sv
module pattern_lfsr
    import tx_test_pattern_pkg::*;
#(
    parameter int LEN   = 11,
    parameter int TAP_A = 10,
    parameter int TAP_B = 8
)(
    input  wire logic           clk,
    input  wire logic           arst_n,
    input  wire logic           load,
    input  wire logic           advance,
    output logic [LEN-1:0]      state,
    output logic                next_bit
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [LEN-1:0] shift;
    } lfsr_state_t;

    lfsr_state_t r_reg;
    lfsr_state_t r_next;

    // Bit 0 is the newest; the feedback reads older bits
    assign next_bit = r_reg.shift[TAP_A] ^ r_reg.shift[TAP_B];
    assign state    = r_reg.shift;

    // Load wins so a pattern always restarts from the all-ones seed
    always_comb
    begin
        r_next = r_reg;
        if (load)
        begin
            r_next.shift = '1;
        end
        else if (advance)
        begin
            r_next.shift = {r_reg.shift[LEN-2:0], next_bit};
        end
    end

    // Seed of all ones; all zero would lock the register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r_reg <= '1;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

endmodule : pattern_lfsr

// File: rtl/tx_test_pattern_gen.sv
// Contract
// - Alternating pattern optional; no jitter duty there
// - Alternating pattern sends plus one, minus one
// - Alternating symbols timed by slave symbol clock
// - Scrambler pattern emits one symbol per 15ns; here one per clk, 25ns at CLK_PERIOD_PS
// - Pair 00,01,10,11 maps 0,+1,0,-1
// - Spectral pattern sends random side-stream scrambled symbols
// - Symbol clock brought out for jitter measurement
// - Control enables the symbol clock output
// - Pattern from 2047 sequence, taps eleven, nine
// - Ternary codes drive three distinct line levels
module tx_test_pattern_gen
    import tx_test_pattern_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic [MODE_W-1:0]  test_mode,
    input  wire logic               tclk_enable,
    input  wire logic [SYM_W-1:0]   normal_sym,
    output logic [SYM_W-1:0]        tx_sym,
    output logic                    tx_level_pos,
    output logic                    tx_level_neg,
    output logic                    pattern_active,
    output logic                    symbol_rate_clock_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [MODE_W-1:0] mode_s1;
        logic [MODE_W-1:0] mode_s2;
        logic [MODE_W-1:0] mode_s3;
        logic              tclk_s1;
        logic              tclk_s2;
        pattern_state_t    state;
        logic              alt_phase;
        logic [SYM_W-1:0]  sym;
        logic              pos;
        logic              neg;
        logic              tclk_gate;
    } gen_state_t;

    gen_state_t r_reg;
    gen_state_t r_next;

    logic [PN_LEN-1:0]  pn_state;
    logic               pn_bit;
    logic [SS_LEN-1:0]  ss_state;
    logic               ss_bit;
    logic               pattern_bit_high;
    logic               pattern_bit_low;
    logic               ss_bit_high;

    // Pair mapping: low bit gates the symbol, high bit picks the sign
    function automatic logic [SYM_W-1:0] map_pair(input logic hi, input logic lo);
        logic [SYM_W-1:0] s;
        s = SYM_ZERO;
        if (lo)
        begin
            s = hi ? SYM_NEG : SYM_POS;
        end
        return s;
    endfunction : map_pair

    // ****************************************************************
    // Sequence sources
    // ****************************************************************
    // The 2047 pattern only runs in its own mode and reseeds otherwise
    pattern_lfsr #(
        .LEN   (PN_LEN),
        .TAP_A (PN_TAP_A),
        .TAP_B (PN_TAP_B)
    ) u_pn (
        .clk      (clk),
        .arst_n   (arst_n),
        .load     (r_reg.state != ST_TM4),
        .advance  (r_reg.state == ST_TM4),
        .state    (pn_state),
        .next_bit (pn_bit)
    );

    // Side-stream scrambler free runs like the normal path's scrambler
    pattern_lfsr #(
        .LEN   (SS_LEN),
        .TAP_A (SS_TAP_A),
        .TAP_B (SS_TAP_B)
    ) u_ss (
        .clk      (clk),
        .arst_n   (arst_n),
        .load     (1'b0),
        .advance  (1'b1),
        .state    (ss_state),
        .next_bit (ss_bit)
    );

    // Low bit is the newest pattern bit, high bit mixes two older ones
    assign pattern_bit_low  = pn_bit;
    assign pattern_bit_high = pn_state[PN_HIST_A] ^ pn_state[PN_HIST_B];
    assign ss_bit_high      = ss_state[SS_HIST_A] ^ ss_state[SS_HIST_B];

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Mode and clock-enable pins are asynchronous, so two flops first.
    // Codes other than 3, 4 and 5 fall back to the normal path.
    always_comb
    begin
        r_next         = r_reg;
        r_next.mode_s1 = test_mode;
        r_next.mode_s2 = r_reg.mode_s1;
        r_next.mode_s3 = r_reg.mode_s2;
        r_next.tclk_s1 = tclk_enable;
        r_next.tclk_s2 = r_reg.tclk_s1;
        // Code bits may land a cycle apart; a code is taken only after it has
        // held for two samples, so a passing mix never starts a pattern.
        if (r_reg.mode_s2 == r_reg.mode_s3)
        begin
            case (r_reg.mode_s2)
                TM_CODE_3: r_next.state = TM3_SUPPORTED ? ST_TM3 : ST_NORMAL;
                TM_CODE_4: r_next.state = ST_TM4;
                TM_CODE_5: r_next.state = ST_TM5;
                default:   r_next.state = ST_NORMAL;
            endcase
        end
        // One symbol per clock: clk is the symbol clock, and in slave
        // timing it is the recovered clock, so the pattern follows it.
        case (r_reg.state)
            ST_TM3:
            begin
                r_next.sym       = r_reg.alt_phase ? SYM_NEG : SYM_POS;
                r_next.alt_phase = ~r_reg.alt_phase;
            end
            ST_TM4:
            begin
                r_next.sym       = map_pair(pattern_bit_high, pattern_bit_low);
                r_next.alt_phase = 1'b0;
            end
            ST_TM5:
            begin
                r_next.sym       = map_pair(ss_bit_high, ss_bit);
                r_next.alt_phase = 1'b0;
            end
            default:
            begin
                r_next.sym       = normal_sym;
                r_next.alt_phase = 1'b0;
            end
        endcase
        // Three line levels; an invalid code from the normal path drives zero
        r_next.pos       = (r_next.sym == SYM_POS);
        r_next.neg       = (r_next.sym == SYM_NEG);
        // Clock out on demand, and always while a pattern is on
        r_next.tclk_gate = r_reg.tclk_s2 || (r_reg.state != ST_NORMAL);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign tx_sym         = r_reg.sym;
    assign tx_level_pos   = r_reg.pos;
    assign tx_level_neg   = r_reg.neg;
    assign pattern_active = (r_reg.state != ST_NORMAL);
    // Gate changes just after a rising edge, so the first high phase after
    // enabling may be short; measure after the clock has settled.
    assign symbol_rate_clock_out = clk & r_reg.tclk_gate;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_tm3_only_if_supported;
        @(posedge clk) disable iff (!arst_n)
        (r_reg.state == ST_TM3) |-> TM3_SUPPORTED;
    endproperty
    a_tm3_only_if_supported: assert property (p_tm3_only_if_supported)
        else $error("alternating pattern active although unsupported");

    property p_tm3_alternates;
        @(posedge clk) disable iff (!arst_n)
        (r_reg.state == ST_TM3) [*2] |=> (tx_sym != $past(tx_sym)) &&
            ((tx_sym == SYM_POS) || (tx_sym == SYM_NEG));
    endproperty
    a_tm3_alternates: assert property (p_tm3_alternates)
        else $error("alternating pattern did not alternate plus and minus");

    property p_tm3_starts_plus;
        @(posedge clk) disable iff (!arst_n)
        (r_reg.state == ST_TM3) && !$past(r_reg.state == ST_TM3) |=> tx_sym == SYM_POS;
    endproperty
    a_tm3_starts_plus: assert property (p_tm3_starts_plus)
        else $error("alternating pattern did not start with plus one");

    property p_tm4_steps_each_symbol;
        @(posedge clk) disable iff (!arst_n)
        (r_reg.state == ST_TM4) |=> pn_state == {$past(pn_state[PN_LEN-2:0]), $past(pn_bit)};
    endproperty
    a_tm4_steps_each_symbol: assert property (p_tm4_steps_each_symbol)
        else $error("pattern sequence did not step on a symbol");

    property p_tm4_zero_on_low;
        @(posedge clk) disable iff (!arst_n)
        (r_reg.state == ST_TM4) && !pattern_bit_low |=> tx_sym == SYM_ZERO;
    endproperty
    a_tm4_zero_on_low: assert property (p_tm4_zero_on_low)
        else $error("low bit clear but symbol not zero");

    property p_tm4_sign;
        @(posedge clk) disable iff (!arst_n)
        (r_reg.state == ST_TM4) && pattern_bit_low |=>
            tx_sym == ($past(pattern_bit_high) ? SYM_NEG : SYM_POS);
    endproperty
    a_tm4_sign: assert property (p_tm4_sign)
        else $error("pattern symbol sign wrong for high bit");

    property p_pn_nonzero;
        @(posedge clk) disable iff (!arst_n)
        (r_reg.state == ST_TM4) |-> (pn_state != '0) && (pn_bit == (pn_state[10] ^ pn_state[8]));
    endproperty
    a_pn_nonzero: assert property (p_pn_nonzero)
        else $error("pattern generator locked or wrong feedback");

    property p_tm5_legal;
        @(posedge clk) disable iff (!arst_n)
        (r_reg.state == ST_TM5) |=> (tx_sym == SYM_ZERO) == !$past(ss_bit);
    endproperty
    a_tm5_legal: assert property (p_tm5_legal)
        else $error("spectral pattern symbol does not follow scrambler");

    property p_levels;
        @(posedge clk) disable iff (!arst_n)
        !(tx_level_pos && tx_level_neg) && (tx_level_pos == (tx_sym == SYM_POS)) &&
            (tx_level_neg == (tx_sym == SYM_NEG));
    endproperty
    a_levels: assert property (p_levels)
        else $error("line levels do not match symbol");

    property p_normal_path;
        @(posedge clk) disable iff (!arst_n)
        (r_reg.state == ST_NORMAL) |=> tx_sym == $past(normal_sym);
    endproperty
    a_normal_path: assert property (p_normal_path)
        else $error("normal path not passed through");

    property p_mode_latency;
        @(posedge clk) disable iff (!arst_n)
        (test_mode == TM_CODE_4) [*5] |-> pattern_active;
    endproperty
    a_mode_latency: assert property (p_mode_latency)
        else $error("test mode not taken within four clocks");

    property p_tclk_enable;
        @(posedge clk) disable iff (!arst_n)
        tclk_enable [*4] |-> r_reg.tclk_gate;
    endproperty
    a_tclk_enable: assert property (p_tclk_enable)
        else $error("symbol clock output not enabled");

endmodule : tx_test_pattern_gen

// File: verification/line_monitor.sv
module line_monitor
    import tx_test_pattern_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             clear_seen,
    input  wire logic [SYM_W-1:0] tx_sym,
    input  wire logic             tx_level_pos,
    input  wire logic             tx_level_neg,
    input  wire logic             symbol_rate_clock_out,
    output logic [2:0]            seen,
    output int                    clash,
    output int                    tclk_edges
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Line sampling
    // ****************************************************************
    initial
    begin
        seen       = 3'h0;
        clash      = 0;
        tclk_edges = 0;
    end

    // Levels seen as {plus, zero, minus}; both drivers on at once is a short on the pair
    always @(posedge clk)
    begin
        seen <= clear_seen ? 3'h0 : (seen | {tx_level_pos & ~tx_level_neg,
                ~tx_level_pos & ~tx_level_neg, tx_level_neg & ~tx_level_pos});
        if ((tx_level_pos && tx_level_neg) || (tx_level_pos !== (tx_sym == SYM_POS))
            || (tx_level_neg !== (tx_sym == SYM_NEG)))
            clash <= clash + 1;
    end

    // The scope triggers on the brought-out symbol clock
    always @(posedge symbol_rate_clock_out)
        tclk_edges <= tclk_edges + 1;

endmodule : line_monitor

// File: verification/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tx_test_pattern_pkg::*;

    typedef struct packed {
        logic [1:0] sym_in;
        logic [1:0] sym_out;
        logic [1:0] lvl;
    } row_t;
    localparam row_t       ROWS [4]       = '{'{2'h0, 2'h0, 2'h0}, '{2'h1, 2'h1, 2'h2},
                                              '{2'h3, 2'h3, 2'h1}, '{2'h2, 2'h2, 2'h0}};
    localparam logic [2:0] IDLE_CODES [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};

    logic              clk;
    logic              arst_n;
    logic [MODE_W-1:0] test_mode;
    logic              tclk_enable;
    logic [SYM_W-1:0]  normal_sym;
    logic [SYM_W-1:0]  tx_sym;
    logic              tx_level_pos;
    logic              tx_level_neg;
    logic              pattern_active;
    logic              symbol_rate_clock_out;
    logic              clear_seen;
    logic [2:0]        seen;
    int                clash;
    int                tclk_edges;
    int                bad_count;
    int                check_count;

    tx_test_pattern_gen i_dut (.clk(clk), .arst_n(arst_n), .test_mode(test_mode), .tclk_enable(tclk_enable),
        .normal_sym(normal_sym), .tx_sym(tx_sym), .tx_level_pos(tx_level_pos), .tx_level_neg(tx_level_neg),
        .pattern_active(pattern_active), .symbol_rate_clock_out(symbol_rate_clock_out));

    line_monitor i_line (.clk(clk), .clear_seen(clear_seen), .tx_sym(tx_sym), .tx_level_pos(tx_level_pos),
        .tx_level_neg(tx_level_neg), .symbol_rate_clock_out(symbol_rate_clock_out), .seen(seen),
        .clash(clash), .tclk_edges(tclk_edges));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        check_count++;
        if (got !== want)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : check

    task automatic give_verdict();
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Drop to the normal path first, so a running pattern cannot pass for the new one
    task automatic enter_mode(input logic [2:0] code);
        @(negedge clk);
        test_mode = 3'h0;
        for (int i = 0; i < 8 && pattern_active !== 1'b0; i++)
            @(negedge clk);
        test_mode = code;
        for (int i = 0; i < 8 && pattern_active !== 1'b1; i++)
            @(negedge clk);
        check(8'(pattern_active), 8'h01);
    endtask : enter_mode

    // Reference sequence always starts from the all-ones seed
    task automatic run_tm4(input int n);
        logic [10:0] hist;
        logic        nb;
        logic        hb;
        logic [1:0]  want;
        hist = 11'h7FF;
        enter_mode(TM_CODE_4);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk);
            nb   = hist[10] ^ hist[8];
            hb   = hist[0] ^ hist[3];
            want = nb ? (hb ? SYM_NEG : SYM_POS) : SYM_ZERO;
            hist = {hist[9:0], nb};
            check(8'(tx_sym), 8'(want));
        end
    endtask : run_tm4

    task automatic clock_pulses(input int n, input int want);
        int start;
        start = tclk_edges;
        repeat (n) @(negedge clk);
        check(8'(tclk_edges - start), 8'(want));
    endtask : clock_pulses

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Whole run is about 2500 cycles; a hang is cut off well beyond that
    initial
    begin
        #(10000 * 25);
        bad_count++;
        give_verdict();
    end

    initial
    begin
        arst_n      = 1'b0;
        test_mode   = 3'h0;
        tclk_enable = 1'b0;
        normal_sym  = 2'h0;
        clear_seen  = 1'b0;
        bad_count   = 0;
        check_count = 0;
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        // Idle codes: no pattern, normal symbols pass one cycle late
        foreach (IDLE_CODES[c])
        begin
            test_mode = IDLE_CODES[c];
            repeat (5) @(negedge clk);
            check(8'(pattern_active), 8'h00);
            foreach (ROWS[r])
            begin
                normal_sym = ROWS[r].sym_in;
                @(negedge clk);
                if (ROWS[r].sym_in != 2'h2)
                    check(8'(tx_sym), 8'(ROWS[r].sym_out));
                check(8'({tx_level_pos, tx_level_neg}), 8'(ROWS[r].lvl));
            end
        end
        // Clock output stays off until asked for
        clock_pulses(20, 0);
        tclk_enable = 1'b1;
        repeat (5) @(negedge clk);
        clock_pulses(20, 20);
        tclk_enable = 1'b0;
        repeat (5) @(negedge clk);
        clock_pulses(20, 0);
        // Full period plus wrap, then a later return to mode 4 restarts from the seed
        run_tm4(2060);
        enter_mode(TM_CODE_3);
        for (int i = 0; i < 16; i++)
        begin
            @(negedge clk);
            check(8'(tx_sym), 8'((i % 2) ? SYM_NEG : SYM_POS));
        end
        run_tm4(30);
        // Random pattern reaches all three line levels; clock runs with it
        clear_seen = 1'b1;
        enter_mode(TM_CODE_5);
        clear_seen = 1'b0;
        clock_pulses(200, 200);
        check(8'(seen), 8'h07);
        check(8'(clash != 0), 8'h00);
        // Reset in mid-pattern silences the line, then the seed is reloaded
        enter_mode(TM_CODE_4);
        repeat (7) @(negedge clk);
        arst_n    = 1'b0;
        test_mode = 3'h0;
        @(posedge clk);
        #1;
        check(8'({tx_sym, tx_level_pos, tx_level_neg, pattern_active, symbol_rate_clock_out}), 8'h00);
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        run_tm4(20);
        // Leaving the pattern returns to the normal path
        test_mode  = 3'h0;
        normal_sym = SYM_NEG;
        repeat (6) @(negedge clk);
        check(8'({pattern_active, tx_sym}), 8'(SYM_NEG));
        give_verdict();
    end

endmodule : tb
